// ===== ics_bus_model.sv
// Far side of the two-wire bus: line monitor and other stations.
// Assumes start, stop and abort as one-cycle pulses, restart as a level.
`timescale 1ns/1ps
module ics_bus_model (
   // Clock, reset and block controls
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic gen_start_i,
   input  wire logic gen_stop_i,
   input  wire logic abort_i,
   input  wire logic rstart_i,
   // Another master holding the bus
   input  wire logic foreign_i,
   // Line events seen by the block
   output logic      bus_active_o,
   output logic      start_det_o,
   output logic      stop_det_o,
   output logic      rstart_sent_o
);
   logic       own_q;
   logic       fq;
   logic [1:0] rs_q;
   // Released lines float high, so the bus reads free
   assign bus_active_o = own_q | foreign_i;
   always_ff @(posedge clk_i) begin
      start_det_o   <= ~rst_i & (gen_start_i | rs_q[1]);
      stop_det_o    <= ~rst_i & (gen_stop_i | (fq & ~foreign_i));
      rs_q          <= rst_i ? 2'h0 : {rs_q[0], rstart_i & ~(|rs_q) & ~rstart_sent_o};
      rstart_sent_o <= ~rst_i & rs_q[1];
      fq            <= ~rst_i & foreign_i;
      own_q         <= ~rst_i & ~gen_stop_i & ~abort_i & (own_q | gen_start_i);
   end
endmodule

// ===== ics_pkg.sv
// Constants of the two-wire controller register block.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package ics_pkg;
   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_CONTROL   = 16'hE602;
   localparam logic [15:0] IDX_STATUS    = 16'hE604;
   localparam logic [15:0] IDX_OWN_ADDR  = 16'hE606;
   localparam logic [15:0] IDX_BUFFER    = 16'hE608;
   localparam int          ADR_W         = 18;
   localparam logic [15:0] REG_RESET     = 16'h0000;
   localparam logic [31:0] BUF_RESET     = 32'h0000_0000;
   // Control fields
   localparam int CTL_LEN_LO  = 10;
   localparam int CTL_STOP    = 9;
   localparam int CTL_IGNORE  = 8;
   localparam int CTL_TX      = 7;
   localparam int CTL_FLGCLR  = 6;
   localparam int CTL_ACKNOWLEDGE_DISABLE  = 5;
   localparam int CTL_BUSY    = 4;
   localparam int CTL_MODE_LO = 2;
   localparam int CTL_RSTART  = 1;
   localparam int CTL_TEN     = 0;
   // Status fields
   localparam int ST_CNT_LO   = 8;
   localparam int ST_END      = 7;
   localparam int ST_PROTO    = 6;
   localparam int ST_DATA     = 5;
   localparam int ST_BUSY     = 4;
   localparam int ST_LRB      = 3;
   localparam int ST_SLAVE    = 2;
   localparam int ST_ARB      = 1;
   localparam int ST_ADDR     = 0;
   // Own address / baud fields
   localparam int OA_DIVMODE  = 15;
   localparam int OA_PRE_LO   = 13;
   localparam logic [15:0] OA_MASK_7BIT  = 16'hE0FE;
   localparam logic [15:0] OA_MASK_10BIT = 16'hE3FF;
   // Mode codes
   localparam logic [1:0] MODE_OFF    = 2'h0;
   localparam logic [1:0] MODE_SLAVE  = 2'h1;
   localparam logic [1:0] MODE_MASTER = 2'h2;
   localparam logic [1:0] MODE_MULTI  = 2'h3;
   // Pre-divider codes and counts
   localparam logic [1:0] PRE_NONE = 2'h0;
   localparam logic [1:0] PRE_8    = 2'h1;
   localparam logic [1:0] PRE_64   = 2'h2;
   localparam logic [5:0] PRE_8_LAST  = 6'h07;
   localparam logic [5:0] PRE_64_LAST = 6'h3F;
   // Byte counter
   localparam logic [2:0] CNT_MAX  = 3'h4;
   localparam logic [2:0] CNT_ZERO = 3'h0;
   // Address matching
   localparam logic [7:0] GENERAL_CALL = 8'h00;
   localparam logic [4:0] TEN_BIT_HDR  = 5'h1E;
endpackage

// ===== ics_regs.sv
// Control, status and own-address/baud registers of a two-wire bus controller.
// Assumes a serial engine outside that reports bus events as one-cycle pulses.
//
// How it works
// - Two-bit length field picks one to four buffer bytes per transfer.
// - Stop request yields stop after next transmission, clears busy; bus stop clears it.
// - Ignore bit clear halts controller on end-of-transfer event; set carries on.
// - Writing the buffer sets transmit select; zero means nothing is sent.
// - Slave transmitter clears transmit select after its final byte.
// - Flag clear control zero lets buffer access clear data event flag.
// - Acknowledge disable zero acknowledges each byte; one does not; stop clears it.
// - Master modes: setting busy makes start, clearing it makes stop at once.
// - Busy set while bus busy is refused and flags arbitration lost; never in slave.
// - Mode field: off and aborting, slave, single-master, multi-master.
// - Repeated start trigger emits repeated start in master modes, then clears itself.
// - Ten-bit select picks 7-bit address bits 7..1 or 10-bit bits 9..0.
// - Read-only byte counter reports correctly transferred bytes, zero to four.
// - Status holds end, protocol and data event flags at bits 7, 6, 5.
// - Bus busy flag shows bus use and reads zero while disabled.
// - Last received bit holds ack, cleared by buffer access; high sets transmit in slave.
// - Slave selected on own or general call address; zero as master.
// - Arbitration loss sets lost and protocol flags, runs to ninth clock, drops to slave in multi-master mode.
// - Slave address phase flag stays set from start until full address or a non-matching 10-bit header arrives.
// - Divider mode bit picks reciprocal or fractional divider.
// - Pre-divider code off, by 8, by 64; code 11 divides by one as off does.
// - In 7-bit mode address bits 9, 8, 0 read zero; 10-bit keeps all.
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module ics_regs (
   // Clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   // Wishbone slave
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [ics_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [31:0]               wb_dat_i,
   output logic      [31:0]               wb_dat_o,
   output logic                           wb_ack_o,
   // Events from the serial engine
   input  wire logic                      bus_active_i,
   input  wire logic                      start_det_i,
   input  wire logic                      stop_det_i,
   input  wire logic                      byte_done_i,
   input  wire logic                      ack_bit_i,
   input  wire logic [7:0]                rx_byte_i,
   input  wire logic                      rx_store_i,
   input  wire logic                      end_xfer_i,
   input  wire logic                      arb_lost_i,
   input  wire logic                      ninth_clk_i,
   input  wire logic                      rstart_sent_i,
   input  wire logic                      slave_tx_last_i,
   // Controls to the serial engine
   output logic      [1:0]                mode_o,
   output logic      [1:0]                buffer_length_select_o,
   output logic      [31:0]               buffer_o,
   output logic                           transmit_select_o,
   output logic                           ack_enable_o,
   output logic                           master_role_o,
   output logic                           halt_o,
   output logic                           gen_start_o,
   output logic                           gen_stop_o,
   output logic                           repeated_start_trigger_o,
   output logic                           abort_o,
   output logic                           divider_mode_select_o,
   output logic                           baud_tick_o
);
   // Control state
   logic [1:0]  len_q;
   logic        stop_req_q;
   logic        ignore_q;
   logic        tx_q;
   logic        flgclr_q;
   logic        acknowledge_disable_q;
   logic        busy_q;
   logic [1:0]  mode_q;
   logic        rstart_q;
   logic        ten_q;
   // Status state
   logic [2:0]  cnt_q;
   logic        end_flag_q;
   logic        proto_flag_q;
   logic        data_flag_q;
   logic        lrb_q;
   logic        sla_q;
   logic        arb_q;
   logic        addr_ph_q;
   logic        addr_second_q;
   logic        lost_run_q;
   // Own address, baud and buffer
   logic [15:0] oa_q;
   logic [31:0] buf_q;
   logic [5:0]  pre_cnt_q;
   // Bus outputs and engine pulses
   logic        ack_q;
   logic [31:0] rdat_q;
   logic        start_q;
   logic        stop_q;
   logic        halt_q;
   logic        abort_q;
   logic        tick_q;

   // Bus decode
   logic [15:0] word_idx;
   logic        access;
   logic        wr;
   logic        sel_ctl;
   logic        sel_st;
   logic        sel_oa;
   logic        sel_buf;
   logic [15:0] ctl_rd;
   logic [15:0] st_rd;
   logic [15:0] oa_rd;
   logic [15:0] ctl_w;
   logic [15:0] st_w;
   logic [15:0] oa_w;
   logic [31:0] buf_w;
   logic        wr_ctl;
   logic        wr_st;
   logic        wr_oa;
   logic        buf_acc;
   logic        buf_wr;
   logic [31:0] rd_mux;

   assign word_idx = wb_adr_i[ics_pkg::ADR_W-1:2];
   assign access   = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr       = access & wb_we_i;
   assign sel_ctl  = word_idx == ics_pkg::IDX_CONTROL;
   assign sel_st   = word_idx == ics_pkg::IDX_STATUS;
   assign sel_oa   = word_idx == ics_pkg::IDX_OWN_ADDR;
   assign sel_buf  = word_idx == ics_pkg::IDX_BUFFER;
   assign wr_ctl   = wr & sel_ctl;
   assign wr_st    = wr & sel_st;
   assign wr_oa    = wr & sel_oa;
   assign buf_acc  = access & sel_buf;
   assign buf_wr   = wr & sel_buf;

   assign ctl_rd = {4'h0, len_q, stop_req_q, ignore_q, tx_q, flgclr_q, acknowledge_disable_q, busy_q,
                    mode_q, rstart_q, ten_q};
   assign st_rd  = {5'h00, cnt_q, end_flag_q, proto_flag_q, data_flag_q,
                    bus_active_i & (mode_q != ics_pkg::MODE_OFF), lrb_q, sla_q, arb_q, addr_ph_q};
   assign oa_rd  = oa_q & (ten_q ? ics_pkg::OA_MASK_10BIT : ics_pkg::OA_MASK_7BIT);

   // Byte-lane merge of write data
   assign ctl_w = {wb_sel_i[1] ? wb_dat_i[15:8] : ctl_rd[15:8], wb_sel_i[0] ? wb_dat_i[7:0] : ctl_rd[7:0]};
   assign st_w  = {wb_sel_i[1] ? wb_dat_i[15:8] : st_rd[15:8], wb_sel_i[0] ? wb_dat_i[7:0] : st_rd[7:0]};
   assign oa_w  = {wb_sel_i[1] ? wb_dat_i[15:8] : oa_q[15:8], wb_sel_i[0] ? wb_dat_i[7:0] : oa_q[7:0]};

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         assign buf_w[8*g+7:8*g] = wb_sel_i[g] ? wb_dat_i[8*g+7:8*g] : buf_q[8*g+7:8*g];
      end
   endgenerate

   assign rd_mux = sel_ctl ? {16'h0000, ctl_rd} :
                   sel_st  ? {16'h0000, st_rd}  :
                   sel_oa  ? {16'h0000, oa_rd}  :
                   sel_buf ? buf_q              : 32'h0000_0000;

   // Mode and role decode
   logic master_mode;
   logic slave_role;
   logic busy_rise;
   logic busy_fall;
   logic busy_refused;
   logic stop_now;
   logic drop_to_slave;

   // upper bit of the written mode marks master modes
   assign master_mode   = ctl_w[ics_pkg::CTL_MODE_LO + 1];
   assign slave_role    = (mode_q == ics_pkg::MODE_SLAVE) | ((mode_q == ics_pkg::MODE_MULTI) & ~busy_q);
   // start on set, stop on clear
   assign busy_rise     = wr_ctl & ctl_w[ics_pkg::CTL_BUSY] & ~busy_q & master_mode & ~bus_active_i;
   assign busy_fall     = wr_ctl & ~ctl_w[ics_pkg::CTL_BUSY] & busy_q;
   assign busy_refused  = wr_ctl & ctl_w[ics_pkg::CTL_BUSY] & ~busy_q & master_mode & bus_active_i;
   assign stop_now      = stop_req_q & busy_q & end_xfer_i;
   assign drop_to_slave = lost_run_q & ninth_clk_i & (mode_q == ics_pkg::MODE_MULTI);

   // Address comparison
   logic own_hit_7;
   logic own_hit_hdr;
   logic own_hit_low;
   logic general_call;
   logic addr_byte;
   logic addr_last;
   logic addr_hit;

   assign addr_byte    = addr_ph_q & byte_done_i;
   assign general_call = ~addr_second_q & (rx_byte_i == ics_pkg::GENERAL_CALL);
   assign own_hit_7    = rx_byte_i[7:1] == oa_q[7:1];
   assign own_hit_hdr  = (rx_byte_i[7:3] == ics_pkg::TEN_BIT_HDR) & (rx_byte_i[2:1] == oa_q[9:8]);
   assign own_hit_low  = rx_byte_i == oa_q[7:0];
   assign addr_last    = ~ten_q | addr_second_q | general_call;
   assign addr_hit     = general_call | (ten_q ? (addr_second_q & own_hit_low) : own_hit_7);

   // Wishbone answer one cycle after request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q  <= access;
         rdat_q <= access ? rd_mux : rdat_q;
      end
   end

   // Control register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         len_q    <= ics_pkg::REG_RESET[11:10];
         ignore_q <= 1'b0;
         flgclr_q <= 1'b0;
         mode_q   <= ics_pkg::MODE_OFF;
         ten_q    <= 1'b0;
      end else if (wr_ctl) begin
         len_q    <= ctl_w[ics_pkg::CTL_LEN_LO +: 2];
         ignore_q <= ctl_w[ics_pkg::CTL_IGNORE];
         flgclr_q <= ctl_w[ics_pkg::CTL_FLGCLR];
         mode_q   <= ctl_w[ics_pkg::CTL_MODE_LO +: 2];
         ten_q    <= ctl_w[ics_pkg::CTL_TEN];
      end
   end

   // Busy master and stop request
   always_ff @(posedge clk_i) begin
      if (rst_i || mode_q == ics_pkg::MODE_OFF) begin
         busy_q     <= 1'b0;
         stop_req_q <= 1'b0;
      end else begin
         // busy follows software in master modes
         if (stop_now || drop_to_slave || busy_fall || busy_refused)
            busy_q <= 1'b0;
         else if (busy_rise)
            busy_q <= 1'b1;
         if (stop_det_i || stop_now)
            stop_req_q <= 1'b0;
         else if (wr_ctl && ctl_w[ics_pkg::CTL_STOP])
            stop_req_q <= 1'b1;
      end
   end

   // Transmit select, acknowledge disable, repeated start
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_q     <= 1'b0;
         acknowledge_disable_q <= 1'b0;
         rstart_q <= 1'b0;
      end else begin
         // missing ack in slave role sets transmit
         if (buf_wr || (byte_done_i && ack_bit_i && slave_role))
            tx_q <= 1'b1;
         else if (slave_tx_last_i || arb_lost_i)
            tx_q <= 1'b0;
         else if (wr_ctl)
            tx_q <= ctl_w[ics_pkg::CTL_TX];
         if (stop_det_i)
            acknowledge_disable_q <= 1'b0;
         else if (wr_ctl)
            acknowledge_disable_q <= ctl_w[ics_pkg::CTL_ACKNOWLEDGE_DISABLE];
         if (rstart_sent_i)
            rstart_q <= 1'b0;
         else if (wr_ctl && ctl_w[ics_pkg::CTL_RSTART] && master_mode)
            rstart_q <= 1'b1;
      end
   end

   // Event flags; a hardware set wins over a software clear
   always_ff @(posedge clk_i) begin
      if (rst_i || mode_q == ics_pkg::MODE_OFF) begin
         end_flag_q   <= 1'b0;
         proto_flag_q <= 1'b0;
         data_flag_q  <= 1'b0;
         arb_q        <= 1'b0;
         lost_run_q   <= 1'b0;
      end else begin
         if (end_xfer_i)
            end_flag_q <= 1'b1;
         else if (wr_st && !st_w[ics_pkg::ST_END])
            end_flag_q <= 1'b0;
         if (arb_lost_i || busy_refused || (addr_byte && addr_last && addr_hit))
            proto_flag_q <= 1'b1;
         else if (wr_st && !st_w[ics_pkg::ST_PROTO])
            proto_flag_q <= 1'b0;
         if (byte_done_i)
            data_flag_q <= 1'b1;
         else if ((wr_st && !st_w[ics_pkg::ST_DATA]) || (buf_acc && !flgclr_q))
            data_flag_q <= 1'b0;
         if (arb_lost_i || busy_refused)
            arb_q <= 1'b1;
         else if (wr_st && !st_w[ics_pkg::ST_ARB])
            arb_q <= 1'b0;
         if (arb_lost_i)
            lost_run_q <= 1'b1;
         else if (ninth_clk_i)
            lost_run_q <= 1'b0;
      end
   end

   // Byte counter, last received bit, slave selection, address phase
   always_ff @(posedge clk_i) begin
      if (rst_i || mode_q == ics_pkg::MODE_OFF) begin
         cnt_q         <= ics_pkg::CNT_ZERO;
         lrb_q         <= 1'b0;
         sla_q         <= 1'b0;
         addr_ph_q     <= 1'b0;
         addr_second_q <= 1'b0;
      end else begin
         // count good bytes up to four
         if (start_det_i)
            cnt_q <= ics_pkg::CNT_ZERO;
         else if (byte_done_i && !ack_bit_i && cnt_q != ics_pkg::CNT_MAX)
            cnt_q <= cnt_q + 3'h1;
         if (byte_done_i)
            lrb_q <= ack_bit_i;
         else if (buf_acc)
            lrb_q <= 1'b0;
         if (start_det_i || stop_det_i || busy_q)
            sla_q <= 1'b0;
         else if (addr_byte && addr_last && addr_hit)
            sla_q <= 1'b1;
         if (start_det_i && slave_role) begin
            addr_ph_q     <= 1'b1;
            addr_second_q <= 1'b0;
         end else if (addr_byte) begin
            addr_ph_q     <= ~addr_last & own_hit_hdr;
            addr_second_q <= ~addr_last;
         end
      end
   end

   // Own address and baud controls
   always_ff @(posedge clk_i) begin
      if (rst_i)
         oa_q <= ics_pkg::REG_RESET;
      // 7-bit mode keeps bits 15..13 and 7..1 only
      else if (wr_oa)
         oa_q <= oa_w & (ten_q ? ics_pkg::OA_MASK_10BIT : ics_pkg::OA_MASK_7BIT);
   end

   // Transfer buffer, written by software or by the receiver
   always_ff @(posedge clk_i) begin
      if (rst_i)
         buf_q <= ics_pkg::BUF_RESET;
      else if (buf_wr)
         buf_q <= buf_w;
      else if (rx_store_i && !cnt_q[2])
         buf_q[{cnt_q[1:0], 3'h0} +: 8] <= rx_byte_i;
   end

   // Baud pre-divider tick
   logic [5:0] pre_last;
   logic       pre_wrap;
   // divide by one, 8 or 64
   assign pre_last = (oa_q[ics_pkg::OA_PRE_LO +: 2] == ics_pkg::PRE_8)  ? ics_pkg::PRE_8_LAST  :
                     (oa_q[ics_pkg::OA_PRE_LO +: 2] == ics_pkg::PRE_64) ? ics_pkg::PRE_64_LAST : 6'h00;
   assign pre_wrap = pre_cnt_q >= pre_last;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_cnt_q <= 6'h00;
         tick_q    <= 1'b0;
      end else begin
         pre_cnt_q <= pre_wrap ? 6'h00 : pre_cnt_q + 6'h01;
         tick_q    <= pre_wrap;
      end
   end

   // Engine pulses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_q <= 1'b0;
         stop_q  <= 1'b0;
         halt_q  <= 1'b0;
         abort_q <= 1'b0;
      end else begin
         start_q <= busy_rise;
         stop_q  <= busy_fall | stop_now;
         halt_q  <= (end_flag_q | end_xfer_i) & ~ignore_q;
         abort_q <= wr_ctl & (ctl_w[ics_pkg::CTL_MODE_LO +: 2] == ics_pkg::MODE_OFF)
                    & (mode_q != ics_pkg::MODE_OFF);
      end
   end

   assign wb_dat_o                 = rdat_q;
   assign wb_ack_o                 = ack_q;
   assign mode_o                   = mode_q;
   assign buffer_length_select_o   = len_q;
   assign buffer_o                 = buf_q;
   assign transmit_select_o        = tx_q;
   assign ack_enable_o             = ~acknowledge_disable_q;
   assign master_role_o            = busy_q;
   assign halt_o                   = halt_q;
   assign gen_start_o              = start_q;
   assign gen_stop_o               = stop_q;
   assign repeated_start_trigger_o = rstart_q;
   assign abort_o                  = abort_q;
   assign divider_mode_select_o    = oa_q[ics_pkg::OA_DIVMODE];
   assign baud_tick_o              = tick_q;
endmodule

// ===== ics_regs_props.sv
// Port assertions for the two-wire controller register block.
// Bound into ics_regs; sees its ports only.
`timescale 1ns/1ps
module ics_regs_props (
   // Clock, reset and register bus
   input wire logic                      clk_i,
   input wire logic                      rst_i,
   input wire logic                      wb_cyc_i,
   input wire logic                      wb_stb_i,
   input wire logic                      wb_we_i,
   input wire logic [ics_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0]                wb_sel_i,
   input wire logic [31:0]               wb_dat_i,
   input wire logic                      wb_ack_o,
   // Engine side
   input wire logic                      bus_active_i,
   input wire logic                      stop_det_i,
   input wire logic                      slave_tx_last_i,
   input wire logic [1:0]                mode_o,
   input wire logic [1:0]                buffer_length_select_o,
   input wire logic                      transmit_select_o,
   input wire logic                      ack_enable_o,
   input wire logic                      master_role_o,
   input wire logic                      gen_start_o,
   input wire logic                      abort_o
);
   wire        wr  = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   wire [15:0] idx = wb_adr_i[ics_pkg::ADR_W-1:2];
   wire        on  = mode_o != ics_pkg::MODE_OFF;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
   property p_len; wr && idx == ics_pkg::IDX_CONTROL && wb_sel_i[1] |=> buffer_length_select_o == $past(wb_dat_i[11:10]); endproperty
   a_len: assert property (p_len) else $error("length field not taken");
   property p_tx_set; wr && idx == ics_pkg::IDX_BUFFER |=> transmit_select_o; endproperty
   a_tx_set: assert property (p_tx_set) else $error("buffer write left transmit off");
   property p_tx_clr; slave_tx_last_i && on && !wr |=> !transmit_select_o; endproperty
   a_tx_clr: assert property (p_tx_clr) else $error("transmit not cleared after last byte");
   property p_ack_stop; stop_det_i && on && !wr |=> ack_enable_o; endproperty
   a_ack_stop: assert property (p_ack_stop) else $error("stop left acknowledge disabled");
   property p_busy_ok; $rose(master_role_o) |-> mode_o[1] && !$past(bus_active_i); endproperty
   a_busy_ok: assert property (p_busy_ok) else $error("busy set in slave mode or busy bus");
   property p_start; $rose(master_role_o) |-> gen_start_o; endproperty
   a_start: assert property (p_start) else $error("no start after busy set");
   property p_abort; !on && $past(mode_o) != ics_pkg::MODE_OFF |-> ##[0:1] abort_o; endproperty
   a_abort: assert property (p_abort) else $error("no abort on disable");
endmodule
bind ics_regs ics_regs_props ics_regs_props_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .bus_active_i(bus_active_i), .stop_det_i(stop_det_i), .slave_tx_last_i(slave_tx_last_i),
   .mode_o(mode_o), .buffer_length_select_o(buffer_length_select_o), .transmit_select_o(transmit_select_o),
   .ack_enable_o(ack_enable_o), .master_role_o(master_role_o), .gen_start_o(gen_start_o), .abort_o(abort_o));

// ===== ics_regs_test.sv
// Self-checking bench for ics_regs with the far-side bus model.
// Assumes ics_pkg, ics_regs, ics_bus_model and the bound checker.
`timescale 1ns/1ps
module ics_regs_test;
   localparam logic [15:0] CT = ics_pkg::IDX_CONTROL;
   localparam logic [15:0] ST = ics_pkg::IDX_STATUS;
   localparam logic [15:0] OA = ics_pkg::IDX_OWN_ADDR;
   localparam logic [15:0] BF = ics_pkg::IDX_BUFFER;
   logic                      clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [ics_pkg::ADR_W-1:0] adr = 18'h0;
   logic [3:0]                sel = 4'h0;
   logic [31:0]               dat = 32'h0, dat_o, q;
   logic [5:0]                ev = 6'h00;
   logic                      ack, nack = 1'b0, foreign = 1'b0, busy, sd, pd, rs_sent, rs_trig;
   logic                      tx, ack_en, master, halt, g_start, g_stop, abort, div, tick;
   logic [1:0]                mode, len;
   int                        checks = 0, n_fail = 0, cycles = 0, k;
   ics_regs ics_regs_inst (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .bus_active_i(busy), .start_det_i(sd),
      .stop_det_i(pd), .byte_done_i(ev[5]), .ack_bit_i(nack), .rx_byte_i(8'hA5), .rx_store_i(ev[4]),
      .end_xfer_i(ev[3]), .arb_lost_i(ev[2]), .ninth_clk_i(ev[1]), .rstart_sent_i(rs_sent), .slave_tx_last_i(ev[0]),
      .mode_o(mode), .buffer_length_select_o(len), .buffer_o(), .transmit_select_o(tx), .ack_enable_o(ack_en),
      .master_role_o(master), .halt_o(halt), .gen_start_o(g_start), .gen_stop_o(g_stop),
      .repeated_start_trigger_o(rs_trig), .abort_o(abort), .divider_mode_select_o(div), .baud_tick_o(tick));
   ics_bus_model ics_bus_model_inst (.clk_i(clk), .rst_i(rst), .gen_start_i(g_start), .gen_stop_i(g_stop),
      .abort_i(abort), .rstart_i(rs_trig), .foreign_i(foreign), .bus_active_o(busy), .start_det_o(sd),
      .stop_det_o(pd), .rstart_sent_o(rs_sent));
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         n_fail++;
         close_out;
      end
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", s, exp, got);
      end
   endtask
   task automatic wb(input logic w, input logic [15:0] a, input logic [3:0] sl, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= {a, 2'h0};
      sel <= sl;
      dat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      wb(1'b1, a, 4'hF, d);
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
      wb(1'b0, a, 4'hF, 32'h0);
      chk($sformatf("reg %h mask %h", a, m), q & m, e);
   endtask
   task automatic pulse(input logic [5:0] e);
      ev <= e;
      @(posedge clk);
      ev <= 6'h00;
      @(posedge clk);
   endtask
   task automatic t_regs;
      chk("ack enable", ack_en, 1'b1);
      rd(CT, 32'hFFFFFFFF, 32'h0);
      rd(ST, 32'hFFFFFFFF, 32'h0);
      rd(OA, 32'hFFFFFFFF, 32'h0);
      wr(16'h0001, 32'hFFFF);
      rd(16'h0001, 32'hFFFFFFFF, 32'h0);
      for (k = 0; k < 4; k++) begin
         wr(CT, k << 10);
         rd(CT, 32'h0C00, k << 10);
         chk("length out", len, k);
      end
      wr(CT, 32'h0);
      wr(OA, 32'hDFFF);
      rd(OA, 32'hFFFF, 32'hC0FE);
      chk("divider mode", div, 1'b1);
      wr(CT, 32'h1);
      wr(OA, 32'h43FF);
      rd(OA, 32'hFFFF, 32'h43FF);
      chk("divider mode", div, 1'b0);
      $display("registers done");
   endtask
   task automatic t_baud;
      int c;
      for (k = 0; k < 3; k++) begin
         wr(OA, ((k + 1) % 3) << 13);
         repeat (70) @(posedge clk);
         c = 0;
         repeat (128) begin
            @(posedge clk);
            if (tick === 1'b1) c++;
         end
         chk("baud ticks", c, k == 0 ? 16 : k == 1 ? 2 : 128);
      end
      $display("baud done");
   endtask
   task automatic t_master;
      wr(CT, 32'h000A);
      chk("restart", rs_trig, 1'b1);
      repeat (8) @(posedge clk);
      rd(CT, 32'h0002, 32'h0);
      wr(CT, 32'h0018);
      rd(CT, 32'h0010, 32'h0010);
      rd(ST, 32'h0010, 32'h0010);
      for (k = 1; k < 6; k++) begin
         pulse(6'h20);
         rd(ST, 32'h0700, (k > 4 ? 4 : k) << 8);
      end
      nack <= 1'b1;
      pulse(6'h20);
      nack <= 1'b0;
      rd(ST, 32'h0708, 32'h0408);
      wb(1'b0, BF, 4'hF, 32'h0);
      rd(ST, 32'h0028, 32'h0);
      wb(1'b1, CT, 4'h2, 32'h0200);
      pulse(6'h08);
      chk("halt", halt, 1'b1);
      repeat (4) @(posedge clk);
      rd(CT, 32'h0210, 32'h0);
      rd(ST, 32'h0010, 32'h0);
      wb(1'b1, CT, 4'h2, 32'h0100);
      chk("halt", halt, 1'b0);
      $display("master done");
   endtask
   task automatic t_slave;
      wr(CT, 32'h000C);
      foreign <= 1'b1;
      repeat (3) @(posedge clk);
      wr(CT, 32'h001C);
      rd(CT, 32'h0010, 32'h0);
      rd(ST, 32'h0052, 32'h0052);
      wr(ST, 32'h0);
      rd(ST, 32'h0042, 32'h0);
      pulse(6'h04);
      rd(ST, 32'h0042, 32'h0042);
      wr(CT, 32'h002C);
      chk("ack enable", ack_en, 1'b0);
      foreign <= 1'b0;
      repeat (3) @(posedge clk);
      chk("ack enable", ack_en, 1'b1);
      wr(CT, 32'h0014);
      rd(CT, 32'h0010, 32'h0);
      wr(BF, 32'h12345678);
      chk("transmit", tx, 1'b1);
      pulse(6'h01);
      chk("transmit", tx, 1'b0);
      foreign <= 1'b1;
      wr(CT, 32'h0);
      rd(ST, 32'hFFFF, 32'h0);
      foreign <= 1'b0;
      $display("slave done");
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs;
      t_baud;
      t_master;
      t_slave;
      close_out;
   end
endmodule
